/* File: bench/vas_alert_regs_tb.sv */
// Purpose: Self-checking bench for the alert block
// Assumes: Host model owns the register port
// Notes: Each source is pulsed one cycle, then cleared
`timescale 1ns/10ps
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin errTotal++; \
    $display("BAD %0t %h %h", $time, a, e); end end
module vas_alert_regs_tb;
    import vas_pkg::*;
    logic clk_sys = 1'h0, rst = 1'h1;
    logic [6:0] ev = 7'h00;
    logic [7:0] rd, msk, regAddr, regWdata, regRdata;
    logic regWrite, regRead, swapDetectEnable, alertIrq;
    int errTotal = 0, nCompared = 0;
    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;
    vas_host vas_host_i (.clk_sys, .regRdata, .regWrite, .regRead,
        .regAddr, .regWdata);
    vas_alert_regs vas_alert_regs_i (.clk_sys, .rst, .regWrite, .regRead,
        .regAddr, .regWdata, .regRdata, .dischargeDone(ev[6]),
        .inputTwoLevel(ev[5]), .inputOneLevel(ev[4]),
        .supplyDetectChange(ev[3]), .overTemp(ev[2]), .swapSent(ev[1]),
        .swapDetected(ev[0]), .swapDetectEnable, .alertIrq);
    task automatic wr(input logic [7:0] a, d);
        vas_host_i.acc(1'h1, a, d, rd);
    endtask
    task automatic rdc(input logic [7:0] a, e);
        vas_host_i.acc(1'h0, a, 8'h00, rd);
        `CHK(rd, e)
    endtask
    // One-cycle pulse on the event sources, launched after the next edge
    task automatic pulse(input logic [6:0] v);
        @(posedge clk_sys) #1 ev = v;
        @(posedge clk_sys) #1 ev = 7'h00;
    endtask
    task automatic test_done;
        $display("mismatches %0d compares %0d", errTotal, nCompared);
        if (errTotal == 0 && nCompared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_sys);
        errTotal++;
        test_done;
    end
    // Reset values, arming, then every source through set, mask, clear
    initial begin
        repeat (20) @(posedge clk_sys);
        #1 rst = 1'h0;
        rdc(VAS_ADDR_ARM, 8'h00);
        rdc(VAS_ADDR_FLAGS, 8'h00);
        rdc(VAS_ADDR_MASKS, 8'h7F);
        rdc(8'hB5, 8'h00);
        wr(VAS_ADDR_ARM, 8'h01);
        `CHK(swapDetectEnable, 1'h1)
        wr(VAS_ADDR_ARM, 8'h00);
        rdc(VAS_ADDR_ARM, 8'h01);
        for (int i = 0; i < VAS_NFLAG; i++) begin
            msk = 8'h01 << i;
            @(posedge clk_sys) #1 ev = msk[6:0];
            @(posedge clk_sys) #1 ev = 7'h00;
            wr(VAS_ADDR_FLAGS, ~msk);
            rdc(VAS_ADDR_FLAGS, msk);
            `CHK(alertIrq, 1'h1)
            wr(VAS_ADDR_MASKS, ~msk & 8'h7F);
            `CHK(alertIrq, 1'h0)
            wr(VAS_ADDR_MASKS, 8'h7F);
            wr(VAS_ADDR_FLAGS, msk);
            rdc(VAS_ADDR_FLAGS, 8'h00);
        end
        `CHK(alertIrq, 1'h0)
        rdc(VAS_ADDR_ARM, 8'h00);
        `CHK(swapDetectEnable, 1'h0)
        // Event in its clearing cycle survives; detect beats an arm write
        fork
            wr(VAS_ADDR_FLAGS, 8'h04);
            pulse(7'h04);
        join
        rdc(VAS_ADDR_FLAGS, 8'h04);
        fork
            wr(VAS_ADDR_ARM, 8'h01);
            pulse(7'h01);
        join
        rdc(VAS_ADDR_ARM, 8'h00);
        `CHK(swapDetectEnable, 1'h0)
        rdc(VAS_ADDR_FLAGS, 8'h05);
        wr(VAS_ADDR_FLAGS, 8'h05);
        rdc(VAS_ADDR_FLAGS, 8'h00);
        `CHK(alertIrq, 1'h0)
        rdc(8'hB1, 8'h00);
        test_done;
    end
endmodule

/* File: bench/vas_host.sv */
// Purpose: Port manager model on the register port
// Assumes: One strobe per access, one cycle long
// Notes: Signals change 1 ns after the rising edge
`timescale 1ns/10ps
module vas_host (
    input wire logic clk_sys,
    input wire logic [7:0] regRdata,
    output logic regWrite = 1'h0,
    output logic regRead = 1'h0,
    output logic [7:0] regAddr = 8'h00,
    output logic [7:0] regWdata = 8'h00
);
    // One byte access; strobe held across exactly one taking edge
    task automatic acc(input logic w, input logic [7:0] a, d,
                       output logic [7:0] q);
        @(posedge clk_sys) #1;
        regWrite = w;
        regRead = !w;
        regAddr = a;
        regWdata = d;
        @(posedge clk_sys) #1;
        {regWrite, regRead} = 2'h0;
        q = regRdata;
    endtask
endmodule

/* File: bench/vas_props.sv */
// Purpose: Port checks for the alert block
// Assumes: One clock, sync reset
// Notes: Mask and flag state is not visible here
`timescale 1ns/10ps
module vas_props (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic swapDetected,
    input wire logic swapDetectEnable,
    input wire logic alertIrq
);
    import vas_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence armHit;
        regWrite && regAddr == VAS_ADDR_ARM && regWdata[0];
    endsequence
    // Arm, detect, readback and reset relations
    arm_set_a: assert property ((armHit ##0 !swapDetected) |=>
        swapDetectEnable) else $error("arm write lost");
    arm_cause_a: assert property ($rose(swapDetectEnable) |->
        $past(regWrite && regAddr == VAS_ADDR_ARM && regWdata[0]))
        else $error("arm rose alone");
    arm_clear_a: assert property (swapDetected |=>
        !swapDetectEnable) else $error("arm not cleared");
    read_arm_a: assert property (regRead && regAddr == VAS_ADDR_ARM |=>
        regRdata == {7'h00, $past(swapDetectEnable)}) else $error("arm rd");
    flag_top_a: assert property (regRead && regAddr == VAS_ADDR_FLAGS |=>
        !regRdata[7]) else $error("flag bit 7 set");
    mask_top_a: assert property (regRead &&
        regAddr == VAS_ADDR_MASKS |=> !regRdata[7])
        else $error("mask bit 7 set");
    read_hole_a: assert property (regRead &&
        regAddr > VAS_ADDR_MASKS |=> regRdata == 8'h00)
        else $error("unmapped read");
    irq_drop_a: assert property ($fell(alertIrq) |->
        $past(rst || (regWrite && (regAddr == VAS_ADDR_FLAGS ||
        regAddr == VAS_ADDR_MASKS)))) else $error("irq dropped alone");
    reset_val_a: assert property ($fell(rst) |-> regRdata == 8'h00 &&
        !alertIrq && !swapDetectEnable) else $error("reset values");
endmodule
bind vas_alert_regs vas_props vas_props_i (.clk_sys, .rst, .regWrite,
    .regRead, .regAddr, .regWdata, .regRdata, .swapDetected,
    .swapDetectEnable, .alertIrq);

/* File: rtl/vas_alert_regs.sv */
// Purpose: Swap detect arm, vendor alert flags and masks with interrupt
// Assumes: Host register port is a simple byte read/write strobe port
// Assumes: Level and pulse sources are synchronous to clk_sys
// Notes: Event inputs are one-cycle pulses except the two input levels
// Notes: A held pulse input sets its flag again on every cycle, so
// a host clear only sticks once the source has gone quiet
//
// What this block does
// - Bit 0 at B2h: write one arms detection
// - Detected swap clears the arm bit
// - Alert flags reset zero, write-one clears
// - Discharge success sets alert bit 6
// - Second input change sets alert bit 5
// - First input change sets alert bit 4
// - Supply detect change sets alert bit 3
// - Over-temperature sets alert bit 2
// - Swap sent on input low sets bit 1
// - Swap request received sets alert bit 0
// - Mask at B4h, one unmasks, reset 7Fh
`timescale 1ns/10ps
module vas_alert_regs (
    // Clock, reset and host register port
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // Event sources from the port logic
    input wire logic dischargeDone,
    input wire logic inputTwoLevel,
    input wire logic inputOneLevel,
    input wire logic supplyDetectChange,
    input wire logic overTemp,
    input wire logic swapSent,
    input wire logic swapDetected,
    // Status towards the swap logic and the host
    output logic swapDetectEnable,
    output logic alertIrq
);
    import vas_pkg::*;

    // Register map, one byte per offset:
    //   B2h bit 0 arms swap detection, upper bits read zero
    //   B3h bits 6..0 alert flags, write one to clear
    //   B4h bits 6..0 masks, a one lets the flag reach the interrupt
    //   Other offsets ignore writes and read as zero

    // Reads are registered: a read and a clear in one cycle return
    // the flags as they stood before the clear

    // Write strobes per register, plus arm set and clear terms
    logic armWr;
    logic flagWr;
    logic maskWr;
    logic armSet;
    logic armClr;

    // Change pulses from the two level inputs
    logic inTwoChg;
    logic inOneChg;

    // Event sources in flag order, clear strobes and live alerts
    logic [VAS_NFLAG-1:0] events;
    logic [VAS_NFLAG-1:0] clrBits;
    logic [VAS_NFLAG-1:0] pending;

    // Register state and next values
    logic arm_r;
    logic arm_nxt;
    logic [VAS_NFLAG-1:0] flags_r;
    logic [VAS_NFLAG-1:0] flags_nxt;
    logic [VAS_NFLAG-1:0] masks_r;
    logic [VAS_NFLAG-1:0] masks_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Address decode, reused for every write strobe
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // Pads a flag-wide field to a byte; bit 7 always reads zero
    function automatic logic [7:0] pad_byte(input logic [6:0] v);
        pad_byte = {1'b0, v};
    endfunction

    assign armWr = regWrite && hit(regAddr, VAS_ADDR_ARM);
    assign flagWr = regWrite && hit(regAddr, VAS_ADDR_FLAGS);
    assign maskWr = regWrite && hit(regAddr, VAS_ADDR_MASKS);

    // Level inputs turned into change pulses
    // The first sample after reset raises no pulse
    vas_change_detect u_in_two (
        .clk_sys(clk_sys),
        .rst(rst),
        .level(inputTwoLevel),
        .changed(inTwoChg)
    );
    vas_change_detect u_in_one (
        .clk_sys(clk_sys),
        .rst(rst),
        .level(inputOneLevel),
        .changed(inOneChg)
    );

    // Gather event sources into flag positions
    // Level inputs enter as change pulses, the rest as they come
    always_comb begin
        events = '0;
        events[VAS_BIT_DISCH] = dischargeDone;
        events[VAS_BIT_IN_TWO] = inTwoChg;
        events[VAS_BIT_IN_ONE] = inOneChg;
        events[VAS_BIT_SUPPLY] = supplyDetectChange;
        events[VAS_BIT_OVERTEMP] = overTemp;
        events[VAS_BIT_SWAP_TX] = swapSent;
        events[VAS_BIT_SWAP_RX] = swapDetected;
    end

    // Per-flag clear strobes; a zero bit in the written byte keeps it
    generate
        for (genvar g = 0; g < VAS_NFLAG; g++) begin : g_clr
            assign clrBits[g] = flagWr && regWdata[g];
        end
    endgenerate

    // Arm is set only by a written one; any detected swap disarms
    assign armSet = armWr && regWdata[VAS_BIT_ARM];
    assign armClr = swapDetected;

    // Arm bit: writing zero does nothing; a detect beats a write, so a
    // swap in the arming cycle leaves detection off and needs a re-arm
    always_comb begin
        arm_nxt = arm_r;
        if (armSet) begin
            arm_nxt = 1'b1;
        end
        if (armClr) begin
            arm_nxt = 1'b0;
        end
    end

    // Arm register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            arm_r <= VAS_RST_ARM[0];
        end else begin
            arm_r <= arm_nxt;
        end
    end

    // Flags: set beats clear so no event is lost in the clear cycle
    // A held pulse source therefore keeps its flag set against clears
    always_comb begin
        flags_nxt = flags_r & ~clrBits;
        flags_nxt = flags_nxt | events;
    end

    // Flag register; nothing pends out of reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags_r <= VAS_RST_FLAGS;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Masks: plain read/write; bit 7 of the written byte is dropped
    // Masking hides a flag from the interrupt but never clears it
    always_comb begin
        masks_nxt = masks_r;
        if (maskWr) begin
            masks_nxt = regWdata[VAS_NFLAG-1:0];
        end
    end

    // Mask register; every source reaches the interrupt out of reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            masks_r <= VAS_RST_MASKS;
        end else begin
            masks_r <= masks_nxt;
        end
    end

    // Read mux; reserved bits and unmapped offsets read zero. Data is
    // held between reads, so the host may pick it up late.
    always_comb begin
        rdata_nxt = rdata_r;
        if (regRead) begin
            unique case (regAddr)
                VAS_ADDR_ARM: rdata_nxt = {7'h00, arm_r};
                VAS_ADDR_FLAGS: rdata_nxt = pad_byte(flags_r);
                VAS_ADDR_MASKS: rdata_nxt = pad_byte(masks_r);
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_r <= VAS_RST_RDATA;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Alerts that are both raised and unmasked
    assign pending = flags_r & masks_r;

    // Data outputs straight from flip-flops
    assign regRdata = rdata_r;
    assign swapDetectEnable = arm_r;

    // Interrupt is a plain OR of registered state, so it drops on the
    // very edge that clears or masks the last pending flag; no extra
    // flop means the host never sees a stale request after its clear
    assign alertIrq = |pending;
endmodule

/* File: rtl/vas_change_detect.sv */
// Purpose: Flags a change of a level input as a one-cycle pulse
// Assumes: Input is synchronous to clk_sys
// Notes: First sample after reset is taken without raising a pulse
`timescale 1ns/10ps
module vas_change_detect (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic level,
    output logic changed
);
    logic prev_r;
    logic prev_nxt;
    logic primed_r;
    logic primed_nxt;

    // Remember last level; hold off until one sample is known
    always_comb begin
        prev_nxt = level;
        primed_nxt = 1'b1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_r <= 1'b0;
            primed_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            primed_r <= primed_nxt;
        end
    end

    assign changed = primed_r && (level != prev_r);
endmodule

/* File: rtl/vas_pkg.sv */
// Purpose: Constants shared by the vendor alert and swap detect block
// Assumes: Byte-wide register port, 8-bit offsets
// Notes: Offsets are the printed register addresses
package vas_pkg;
    localparam logic [7:0] VAS_ADDR_ARM = 8'hB2;
    localparam logic [7:0] VAS_ADDR_FLAGS = 8'hB3;
    localparam logic [7:0] VAS_ADDR_MASKS = 8'hB4;
    localparam logic [7:0] VAS_RST_ARM = 8'h00;
    localparam logic [6:0] VAS_RST_FLAGS = 7'h00;
    localparam logic [6:0] VAS_RST_MASKS = 7'h7F;
    localparam logic [7:0] VAS_RST_RDATA = 8'h00;
    localparam int VAS_NFLAG = 7;
    // Flag bit positions
    localparam int VAS_BIT_SWAP_RX = 0;
    localparam int VAS_BIT_SWAP_TX = 1;
    localparam int VAS_BIT_OVERTEMP = 2;
    localparam int VAS_BIT_SUPPLY = 3;
    localparam int VAS_BIT_IN_ONE = 4;
    localparam int VAS_BIT_IN_TWO = 5;
    localparam int VAS_BIT_DISCH = 6;
    localparam int VAS_BIT_ARM = 0;
endpackage
